// ===== logic/rec_pkg.sv
// Constants, field layouts and state codes shared by the receive error tally bank.
// Overview of operation
// - Functional mode: line tally counts each invalid high-speed code word, disparity errors included.
// - Backplane 64b/66b mode: reading the line tally also clears low byte of 03.0021.
// - Line tally resets to 0x0000 in backplane 64b/66b mode, else 0xFFFD.
// - High-speed pattern verification counts errors of pattern chosen by 1E.000B bits 10:8.
// - Pseudo-random check pin asserted: line tally counts selected PRBS bit errors instead.
// - Every tally returns its value on read and is then cleared, an error in the clearing cycle loading it with one.
// - Lane tallies 0-2 at 0x0011-0x0013 count lane decoder errors in backplane modes.
// - Generic serdes mode: lane tallies count invalid words from lane alignment decoder.
// - Low-speed pattern verification counts errors of pattern chosen by 1E.000B bits 5:4.
package rec_pkg;

  localparam int TALLY_W = 16;
  localparam int LANE_COUNT = 3;
  localparam int HS_PATTERN_COUNT = 8;
  localparam int LS_PATTERN_COUNT = 4;

  // Management frame fields.
  localparam logic [4:0] DEVICE_ADDR = 5'h1e;
  localparam logic [1:0] FRAME_START = 2'h0;
  localparam logic [1:0] OP_ADDRESS = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ_INC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [3:0] HEADER_LAST = 4'hd;
  localparam logic [3:0] DATA_LAST = 4'hf;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  // Register offsets inside the device address space.
  localparam logic [15:0] LINE_SIDE_ERROR_TALLY = 16'h0010;
  localparam logic [15:0] HOST_LANE0_ERROR_TALLY = 16'h0011;
  localparam logic [15:0] HOST_LANE1_ERROR_TALLY = 16'h0012;
  localparam logic [15:0] HOST_LANE2_ERROR_TALLY = 16'h0013;

  // Tally reset values.
  localparam logic [15:0] TALLY_RESET = 16'hfffd;
  localparam logic [15:0] TALLY_RESET_BACKPLANE = 16'h0000;

  // Operating mode codes on MODE_SEL.
  localparam logic [1:0] GENERIC_SERDES_MODE = 2'h0;
  localparam logic [1:0] BACKPLANE_64B66B_MODE = 2'h1;
  localparam logic [1:0] GIGABIT_BACKPLANE_MODE = 2'h2;

  // Frame receiver states.
  typedef enum logic [3:0] {
    ST_PREAMBLE = 4'h1,
    ST_HEADER = 4'h2,
    ST_TURN = 4'h4,
    ST_DATA = 4'h8
  } rec_frame_state_t;

endpackage : rec_pkg

// ===== logic/rec_tally.sv
// One saturating clear-on-read error tally.
`timescale 1ns/100ps
module rec_tally
  import rec_pkg::*;
#(
  parameter int W = TALLY_W,
  parameter logic [W-1:0] RESET_VALUE = TALLY_RESET
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Events and controls.
  input wire logic err_event,
  input wire logic read_clear,
  input wire logic load_zero,
  // Current count.
  output logic [W-1:0] value
);

  logic [W-1:0] value_reg;
  logic [W-1:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (load_zero || read_clear) begin
      value_next = {{(W-1){1'b0}}, err_event};
    end else if (err_event && !(&value_reg)) begin
      value_next = value_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule : rec_tally

// ===== logic/rec_bank.sv
// Receive error tally bank with its management frame slave.
`timescale 1ns/100ps
module rec_bank
  import rec_pkg::*;
#(
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Management interface pins.
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE,
  // Mode and pattern selection.
  input wire logic [1:0] MODE_SEL,
  input wire logic HS_TEST_VERIFY,
  input wire logic [2:0] HS_PATTERN_SEL,
  input wire logic LS_TEST_VERIFY,
  input wire logic [1:0] LS_PATTERN_SEL,
  input wire logic PSEUDO_RANDOM_CHECK_PIN,
  // High-speed error events.
  input wire logic HS_DECODE_ERR,
  input wire logic [HS_PATTERN_COUNT-1:0] HS_PATTERN_ERR,
  input wire logic HS_PRBS_ERR,
  // Low-speed lane error events.
  input wire logic [LANE_COUNT-1:0] LS_DECODE_ERR,
  input wire logic [LANE_COUNT-1:0] LS_ALIGN_DECODE_ERR,
  input wire logic [LANE_COUNT*LS_PATTERN_COUNT-1:0] LS_PATTERN_ERR,
  // Clear strobe toward the forward error correction count.
  output logic FEC_LOW_CLEAR
);

  // Picks the error source of one low-speed lane for the current mode.
  function automatic logic lane_error(
    input logic [1:0] mode,
    input logic verify,
    input logic [1:0] sel,
    input logic [LS_PATTERN_COUNT-1:0] pattern_err,
    input logic decode_err,
    input logic align_err
  );
    logic result;
    result = decode_err;
    if (verify) begin
      result = pattern_err[sel];
    end else if (mode == GENERIC_SERDES_MODE) begin
      result = align_err;
    end
    return result;
  endfunction : lane_error

  // True when an address falls on one of the four tallies.
  function automatic logic in_bank(input logic [15:0] addr);
    return (addr >= LINE_SIDE_ERROR_TALLY) && (addr <= HOST_LANE2_ERROR_TALLY);
  endfunction : in_bank

  // Pin synchronisers.
  logic mdc_s1_reg;
  logic mdc_s2_reg;
  logic mdc_s3_reg;
  logic mdio_s1_reg;
  logic mdio_s2_reg;
  logic prbs_s1_reg;
  logic prbs_s2_reg;

  // Frame receiver.
  rec_frame_state_t state_reg;
  logic [5:0] ones_reg;
  logic [3:0] cnt_reg;
  logic [12:0] hdr_reg;
  logic [15:0] wr_shift_reg;
  logic [15:0] addr_reg;
  logic [1:0] op_reg;
  logic frame_ok_reg;
  logic rd_active_reg;
  logic [15:0] rd_shift_reg;
  logic mdio_out_reg;
  logic mdio_oe_reg;
  logic fec_clear_reg;
  logic init_reg;

  // Tally plumbing.
  logic [TALLY_W-1:0] tally_value [0:LANE_COUNT];
  logic [LANE_COUNT:0] tally_err;
  logic [LANE_COUNT:0] tally_clear;
  logic [TALLY_W-1:0] line_side_error_value;
  logic mdc_rise;
  logic [13:0] hdr_full;
  logic hdr_done;
  logic hdr_match;
  logic read_hit;
  logic [1:0] read_index;
  logic load_backplane_zero;
  logic line_err;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mdc_s1_reg <= 1'b0;
      mdc_s2_reg <= 1'b0;
      mdc_s3_reg <= 1'b0;
      mdio_s1_reg <= 1'b1;
      mdio_s2_reg <= 1'b1;
      prbs_s1_reg <= 1'b0;
      prbs_s2_reg <= 1'b0;
    end else begin
      mdc_s1_reg <= MDC;
      mdc_s2_reg <= mdc_s1_reg;
      mdc_s3_reg <= mdc_s2_reg;
      mdio_s1_reg <= MDIO_IN;
      mdio_s2_reg <= mdio_s1_reg;
      prbs_s1_reg <= PSEUDO_RANDOM_CHECK_PIN;
      prbs_s2_reg <= prbs_s1_reg;
    end
  end

  assign mdc_rise = mdc_s2_reg && !mdc_s3_reg;
  assign hdr_full = {hdr_reg, mdio_s2_reg};
  assign hdr_done = mdc_rise && (state_reg == ST_HEADER) && (cnt_reg == HEADER_LAST);
  assign hdr_match = (hdr_full[13:12] == FRAME_START) && (hdr_full[9:5] == PORT_ADDR)
                     && (hdr_full[4:0] == DEVICE_ADDR);
  // Only the four tallies are answered; the rest of the space belongs to sibling blocks.
  assign read_hit = hdr_done && hdr_match && hdr_full[11] && in_bank(addr_reg);
  assign read_index = addr_reg[1:0];

  // Frame receiver state machine.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= ST_PREAMBLE;
      ones_reg <= 6'h00;
      cnt_reg <= 4'h0;
      hdr_reg <= 13'h0000;
      wr_shift_reg <= 16'h0000;
      op_reg <= OP_ADDRESS;
      frame_ok_reg <= 1'b0;
    end else if (mdc_rise) begin
      unique case (state_reg)
        ST_PREAMBLE: begin
          if (mdio_s2_reg) begin
            if (ones_reg != PREAMBLE_LEN) begin
              ones_reg <= ones_reg + 6'h01;
            end
          end else if (ones_reg == PREAMBLE_LEN) begin
            state_reg <= ST_HEADER;
            hdr_reg <= 13'h0000;
            cnt_reg <= 4'h1;
          end else begin
            ones_reg <= 6'h00;
          end
        end
        ST_HEADER: begin
          hdr_reg <= hdr_full[12:0];
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == HEADER_LAST) begin
            state_reg <= ST_TURN;
            cnt_reg <= 4'h0;
            op_reg <= hdr_full[11:10];
            frame_ok_reg <= hdr_match;
          end
        end
        ST_TURN: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg != 4'h0) begin
            state_reg <= ST_DATA;
            cnt_reg <= 4'h0;
          end
        end
        ST_DATA: begin
          wr_shift_reg <= {wr_shift_reg[14:0], mdio_s2_reg};
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == DATA_LAST) begin
            state_reg <= ST_PREAMBLE;
            ones_reg <= 6'h00;
            cnt_reg <= 4'h0;
          end
        end
      endcase
    end
  end

  // Register address pointer; writes to the tallies carry no effect.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      addr_reg <= ADDR_RESET;
    end else if (mdc_rise && (state_reg == ST_DATA) && (cnt_reg == DATA_LAST) && frame_ok_reg) begin
      if (op_reg == OP_ADDRESS) begin
        addr_reg <= {wr_shift_reg[14:0], mdio_s2_reg};
      end else if (op_reg == OP_READ_INC) begin
        addr_reg <= addr_reg + 16'h0001;
      end
    end
  end

  // Read data is captured at the same edge that clears the tally, so no count is lost.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_active_reg <= 1'b0;
      rd_shift_reg <= 16'h0000;
    end else if (read_hit) begin
      rd_active_reg <= 1'b1;
      rd_shift_reg <= tally_value[read_index];
    end else if (mdc_rise && rd_active_reg) begin
      if ((state_reg == ST_TURN) && (cnt_reg != 4'h0)) begin
        rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
      end else if (state_reg == ST_DATA) begin
        rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
        if (cnt_reg == DATA_LAST) begin
          rd_active_reg <= 1'b0;
        end
      end
    end
  end

  // Pin driver: released in the first turnaround bit, zero in the second, then data.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mdio_out_reg <= 1'b0;
      mdio_oe_reg <= 1'b0;
    end else if (mdc_rise && rd_active_reg) begin
      if (state_reg == ST_TURN) begin
        mdio_oe_reg <= 1'b1;
        mdio_out_reg <= (cnt_reg == 4'h0) ? 1'b0 : rd_shift_reg[15];
      end else if (state_reg == ST_DATA) begin
        if (cnt_reg == DATA_LAST) begin
          mdio_oe_reg <= 1'b0;
          mdio_out_reg <= 1'b0;
        end else begin
          mdio_out_reg <= rd_shift_reg[15];
        end
      end
    end
  end

  // The mode is caught one edge after reset release, never inside the reset branch.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      init_reg <= 1'b1;
    end else begin
      init_reg <= 1'b0;
    end
  end

  assign load_backplane_zero = init_reg && (MODE_SEL == BACKPLANE_64B66B_MODE);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fec_clear_reg <= 1'b0;
    end else begin
      fec_clear_reg <= read_hit && (read_index == 2'h0) && (MODE_SEL == BACKPLANE_64B66B_MODE);
    end
  end

  // Line side source: PRBS pin first, then pattern check, then decoder.
  always_comb begin
    if (prbs_s2_reg) begin
      line_err = HS_PRBS_ERR;
    end else if (HS_TEST_VERIFY) begin
      line_err = HS_PATTERN_ERR[HS_PATTERN_SEL];
    end else begin
      line_err = HS_DECODE_ERR;
    end
  end

  assign tally_err[0] = line_err;

  always_comb begin
    tally_clear = '0;
    if (read_hit) begin
      tally_clear[read_index] = 1'b1;
    end
  end

  rec_tally #(
    .W(TALLY_W),
    .RESET_VALUE(TALLY_RESET)
  ) u_line_tally (
    .clk(CLK),
    .rst(SYS_RST),
    .err_event(tally_err[0]),
    .read_clear(tally_clear[0]),
    .load_zero(load_backplane_zero),
    .value(line_side_error_value)
  );

  assign tally_value[0] = line_side_error_value;

  generate
    for (genvar lane = 0; lane < LANE_COUNT; lane++) begin : g_lane
      assign tally_err[lane+1] = lane_error(
        MODE_SEL,
        LS_TEST_VERIFY,
        LS_PATTERN_SEL,
        LS_PATTERN_ERR[lane*LS_PATTERN_COUNT +: LS_PATTERN_COUNT],
        LS_DECODE_ERR[lane],
        LS_ALIGN_DECODE_ERR[lane]
      );

      rec_tally #(
        .W(TALLY_W),
        .RESET_VALUE(TALLY_RESET)
      ) u_lane_tally (
        .clk(CLK),
        .rst(SYS_RST),
        .err_event(tally_err[lane+1]),
        .read_clear(tally_clear[lane+1]),
        .load_zero(1'b0),
        .value(tally_value[lane+1])
      );
    end
  endgenerate

  assign MDIO_OUT = mdio_out_reg;
  assign MDIO_OE = mdio_oe_reg;
  assign FEC_LOW_CLEAR = fec_clear_reg;

endmodule : rec_bank

// ===== verif/rec_bank_sva.sv
// Checker for the management pins and clear strobe of the tally bank.
`timescale 1ns/100ps
module rec_bank_sva
  import rec_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Watched pins.
  input wire logic MDIO_OUT,
  input wire logic MDIO_OE,
  input wire logic [1:0] MODE_SEL,
  input wire logic FEC_LOW_CLEAR
);
  int oe_run_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // The length bound assumes the eight-cycle management clock of the bench.
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) oe_run_reg <= 0;
    else oe_run_reg <= MDIO_OE ? oe_run_reg + 1 : 0;
  end
  a_release_quiet: assert property ($fell(SYS_RST) |-> !MDIO_OE && !FEC_LOW_CLEAR)
    else $error("active output after reset");
  a_fec_spacing: assert property (FEC_LOW_CLEAR |=> !FEC_LOW_CLEAR [*8])
    else $error("clear strobe too long");
  a_fec_mode: assert property (FEC_LOW_CLEAR |-> MODE_SEL == BACKPLANE_64B66B_MODE)
    else $error("clear strobe in wrong mode");
  a_fec_then_oe: assert property (FEC_LOW_CLEAR |-> !MDIO_OE ##[4:12] MDIO_OE)
    else $error("clear strobe without answer");
  a_oe_start_low: assert property ($rose(MDIO_OE) |-> !MDIO_OUT)
    else $error("turnaround bit not low");
  a_oe_holds: assert property ($rose(MDIO_OE) |-> MDIO_OE [*8])
    else $error("pin released early");
  a_bit_stands: assert property (MDIO_OE && $changed(MDIO_OUT) |=> $stable(MDIO_OUT) [*6])
    else $error("data bit too short");
  a_word_length: assert property ($fell(MDIO_OE) |-> oe_run_reg inside {[120:150]})
    else $error("answer length wrong");
endmodule : rec_bank_sva

// ===== verif/rec_host.sv
// Management host model that clocks frames into the bank.
`timescale 1ns/100ps
module rec_host
  import rec_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Line and host drive.
  input wire logic mdio,
  output logic mdc,
  output logic drv,
  output logic drv_en
);
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
    drv_en = 1'b0;
  end
  // One period is eight system cycles; the line is sampled as the clock rises.
  task bitx(input logic b, input logic en, output logic s);
    @(posedge clk);
    #1 mdc = 1'b0;
    drv = b;
    drv_en = en;
    repeat (4) @(posedge clk);
    #1 mdc = 1'b1;
    s = mdio;
    repeat (3) @(posedge clk);
    #1;
  endtask : bitx
  // A trailing idle bit lets the bank release the line before the next preamble.
  task frame(input logic [1:0] op, input logic [15:0] d, output logic [15:0] q);
    logic [15:0] hdr;
    logic s;
    hdr = {FRAME_START, op, 5'h00, DEVICE_ADDR, 2'b10};
    repeat (PREAMBLE_LEN) bitx(1'b1, 1'b1, s);
    for (int i = 15; i >= 0; i--) bitx(hdr[i], i > 1 || !op[1], s);
    for (int i = 15; i >= 0; i--) begin
      bitx(d[i], !op[1], s);
      q[i] = s;
    end
    bitx(1'b1, 1'b0, s);
  endtask : frame
endmodule : rec_host

// ===== verif/rec_bank_test.sv
// Self-checking bench for the receive error tally bank.
`timescale 1ns/100ps
module rec_bank_test
  import rec_pkg::*;
();
  logic CLK;
  logic SYS_RST = 1'b1;
  logic [1:0] MODE_SEL = GENERIC_SERDES_MODE;
  logic HS_TEST_VERIFY = 1'b0;
  logic [2:0] HS_PATTERN_SEL = 3'h0;
  logic LS_TEST_VERIFY = 1'b0;
  logic [1:0] LS_PATTERN_SEL = 2'h0;
  logic PSEUDO_RANDOM_CHECK_PIN = 1'b0;
  // Events high to low: decode, patterns, pseudo-random, lane decode, lane align, lane patterns.
  logic [27:0] ev = 28'h0000000;
  logic MDC;
  logic MDIO_OUT;
  logic MDIO_OE;
  logic MDIO_LINE;
  logic FEC_LOW_CLEAR;
  logic drv;
  logic drv_en;
  int oe_n = 0;
  int oe_mark = 0;
  logic [15:0] q;
  int fec_n = 0;
  int errors = 0;
  int check_count = 0;
  // The line has a pull-up, so a released line reads as one.
  assign MDIO_LINE = MDIO_OE ? MDIO_OUT : (drv_en ? drv : 1'b1);
  rec_bank i_rec_bank (
    .CLK(CLK), .SYS_RST(SYS_RST), .MDC(MDC), .MDIO_IN(MDIO_LINE), .MDIO_OUT(MDIO_OUT),
    .MDIO_OE(MDIO_OE), .MODE_SEL(MODE_SEL), .HS_TEST_VERIFY(HS_TEST_VERIFY),
    .HS_PATTERN_SEL(HS_PATTERN_SEL), .LS_TEST_VERIFY(LS_TEST_VERIFY), .LS_PATTERN_SEL(LS_PATTERN_SEL),
    .PSEUDO_RANDOM_CHECK_PIN(PSEUDO_RANDOM_CHECK_PIN), .HS_DECODE_ERR(ev[27]),
    .HS_PATTERN_ERR(ev[26:19]), .HS_PRBS_ERR(ev[18]), .LS_DECODE_ERR(ev[17:15]),
    .LS_ALIGN_DECODE_ERR(ev[14:12]), .LS_PATTERN_ERR(ev[11:0]), .FEC_LOW_CLEAR(FEC_LOW_CLEAR)
  );
  rec_host i_rec_host (.clk(CLK), .mdio(MDIO_LINE), .mdc(MDC), .drv(drv), .drv_en(drv_en));
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (FEC_LOW_CLEAR === 1'b1) fec_n <= fec_n + 1;
    if (MDIO_OE === 1'b1) oe_n <= oe_n + 1;
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task rst(input logic [1:0] m);
    MODE_SEL = m;
    SYS_RST = 1'b1;
    repeat (2) @(posedge CLK);
    #1 SYS_RST = 1'b0;
  endtask : rst
  task pulse(input logic [27:0] v, input int n);
    repeat (n) begin
      @(posedge CLK);
      #1 ev = v;
      @(posedge CLK);
      #1 ev = 28'h0000000;
    end
  endtask : pulse
  task rd(input logic [15:0] a, input logic [15:0] e);
    i_rec_host.frame(OP_ADDRESS, a, q);
    i_rec_host.frame(OP_READ, 16'h0000, q);
    chk(q, e);
  endtask : rd
  // Walks all four tallies with post-incrementing reads.
  task rdall(input logic [63:0] e);
    i_rec_host.frame(OP_ADDRESS, LINE_SIDE_ERROR_TALLY, q);
    for (int i = 0; i < 4; i++) begin
      i_rec_host.frame(OP_READ_INC, 16'h0000, q);
      chk(q, e[63 - 16 * i -: 16]);
    end
  endtask : rdall
  task print_verdict;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (60000) @(posedge CLK);
    errors++;
    print_verdict();
  end
  initial begin
    rst(GENERIC_SERDES_MODE);
    pulse(28'h0002000, 3);
    rdall({TALLY_RESET, TALLY_RESET, 16'hffff, TALLY_RESET});
    rdall(64'h0);
    pulse(28'h8007000, 2);
    pulse(28'h0038000, 3);
    rdall({4{16'h0002}});
    MODE_SEL = GIGABIT_BACKPLANE_MODE;
    pulse(28'h8038000, 1);
    pulse(28'h0030000, 2);
    pulse(28'h0007000, 2);
    rdall({16'h0001, 16'h0001, 16'h0003, 16'h0003});
    chk(16'(fec_n), 16'h0000);
    rst(BACKPLANE_64B66B_MODE);
    rdall({TALLY_RESET_BACKPLANE, {3{TALLY_RESET}}});
    chk(16'(fec_n), 16'h0001);
    MODE_SEL = GENERIC_SERDES_MODE;
    HS_TEST_VERIFY = 1'b1;
    for (int s = 0; s < 8; s++) begin
      HS_PATTERN_SEL = 3'(s);
      pulse(28'h0080000 << s, s + 1);
      pulse(28'h8000000 | (28'h7f80000 & ~(28'h0080000 << s)), 2);
      rd(LINE_SIDE_ERROR_TALLY, 16'(s + 1));
    end
    PSEUDO_RANDOM_CHECK_PIN = 1'b1;
    repeat (3) @(posedge CLK);
    pulse(28'h0040000, 3);
    pulse(28'hc000000, 2);
    rdall({16'h0003, 48'h0});
    PSEUDO_RANDOM_CHECK_PIN = 1'b0;
    LS_TEST_VERIFY = 1'b1;
    for (int s = 0; s < 4; s++) begin
      LS_PATTERN_SEL = 2'(s);
      pulse(28'h0000111 << s, 1);
      pulse(28'h0000110 << s, 1);
      pulse(28'h0000100 << s, 1);
      pulse(28'h003ffff & ~(28'h0000111 << s), 2);
      rdall({16'h0000, 16'h0001, 16'h0002, 16'h0003});
    end
    i_rec_host.frame(OP_ADDRESS, HOST_LANE0_ERROR_TALLY, q);
    i_rec_host.frame(OP_WRITE, 16'h1234, q);
    oe_mark = oe_n;
    rd(16'h0014, 16'hffff);
    chk(16'(oe_n - oe_mark), 16'h0000);
    rd(HOST_LANE0_ERROR_TALLY, 16'h0000);
    // An error held across a clearing read: 367 counts precede the clear edge, then one plus 152 more.
    ev = 28'h0000008;
    i_rec_host.frame(OP_READ, 16'h0000, q);
    ev = 28'h0000000;
    chk(q, 16'h016f);
    rd(HOST_LANE0_ERROR_TALLY, 16'h0099);
    print_verdict();
  end
endmodule : rec_bank_test
bind rec_bank rec_bank_sva i_rec_bank_sva (.CLK(CLK), .SYS_RST(SYS_RST), .MDIO_OUT(MDIO_OUT),
  .MDIO_OE(MDIO_OE), .MODE_SEL(MODE_SEL), .FEC_LOW_CLEAR(FEC_LOW_CLEAR));
